// File: src/cpu_addr_regs.svh
`ifndef CPU_ADDR_REGS_SVH
`define CPU_ADDR_REGS_SVH

// Prebyte codes
`define PRE_SWAP_Y 8'h90
`define PRE_IND_Y 8'h91
`define PRE_IND 8'h92

// Special inherent opcodes
`define OP_MASK_IRQ 8'h9B
`define OP_UNMASK_IRQ 8'h9A
`define OP_SLEEP_IRQ 8'h8F
`define OP_HALT 8'h8E

// Interrupt mask levels and reset value
`define IRQ_LEVEL_MAX 2'h3
`define IRQ_LEVEL_MIN 2'h0
`define IRQ_MASK_RST 2'h3

// Address space figures
`define PAGE_ZERO 8'h00
`define SIDX_LIMIT 16'h01FE
`define LEN_RST 3'h0
`define ADDR_RST 16'h0000
`define BYTE_RST 8'h00

`endif

// File: src/cpu_addr_pkg.sv
package cpu_addr_pkg;

  // Seventeen operand addressing modes
  typedef enum logic [4:0] {
    M_INH, M_IMM, M_SDIR, M_LDIR, M_IDX0, M_SIDX, M_LIDX, M_SIND, M_LIND,
    M_SIIDX, M_LIIDX, M_RELD, M_RELI, M_BITD, M_BITI, M_BITRD, M_BITRI
  } mode_t;

  typedef enum logic [3:0] {
    F_INH, F_IMM, F_SDIR, F_LDIR, F_IDX0, F_SIDX, F_LIDX, F_REL, F_BIT, F_BITREL
  } family_t;

  typedef enum logic [8:0] {
    ST_OPC = 9'h001,
    ST_A1 = 9'h002,
    ST_A2 = 9'h004,
    ST_REL = 9'h008,
    ST_P1 = 9'h010,
    ST_P2 = 9'h020,
    ST_OUT = 9'h040,
    ST_SLEEP = 9'h080,
    ST_HALT = 9'h100
  } state_t;

  typedef struct packed {
    family_t family;
    logic rmw;
    logic mask_set;
    logic mask_clr;
    logic sleep_until_irq_instr;
    logic halt;
  } opclass_t;

  typedef struct packed {
    mode_t mode;
    logic [15:0] addr;
    logic [7:0] operand;
    logic [15:0] target;
    logic [2:0] length;
    logic prebyte;
    logic use_y;
    logic rmw;
  } result_t;

endpackage : cpu_addr_pkg

// File: src/op_classify.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_addr_regs.svh"

module op_classify (
  // Opcode in
  input wire logic [7:0] opcode,
  // Class out
  output cpu_addr_pkg::opclass_t cls
);

  always_comb begin
    cls = '0;
    cls.family = cpu_addr_pkg::F_INH;
    case (opcode[7:4])
      4'h0: begin
        cls.family = cpu_addr_pkg::F_BITREL;
        cls.rmw = 1'b1;
      end
      4'h1: begin
        cls.family = cpu_addr_pkg::F_BIT;
        cls.rmw = 1'b1;
      end
      4'h2: cls.family = cpu_addr_pkg::F_REL;
      4'h3: begin
        cls.family = cpu_addr_pkg::F_SDIR;
        cls.rmw = 1'b1;
      end
      4'h6: begin
        cls.family = cpu_addr_pkg::F_SIDX;
        cls.rmw = 1'b1;
      end
      4'h7: begin
        cls.family = cpu_addr_pkg::F_IDX0;
        cls.rmw = 1'b1;
      end
      4'hA: cls.family = cpu_addr_pkg::F_IMM;
      4'hB: cls.family = cpu_addr_pkg::F_SDIR;
      4'hC: cls.family = cpu_addr_pkg::F_LDIR;
      4'hD: cls.family = cpu_addr_pkg::F_LIDX;
      4'hE: cls.family = cpu_addr_pkg::F_SIDX;
      4'hF: cls.family = cpu_addr_pkg::F_IDX0;
      default: cls.family = cpu_addr_pkg::F_INH;
    endcase
    cls.mask_set = (opcode == `OP_MASK_IRQ);
    cls.mask_clr = (opcode == `OP_UNMASK_IRQ);
    cls.sleep_until_irq_instr = (opcode == `OP_SLEEP_IRQ);
    cls.halt = (opcode == `OP_HALT);
  end

endmodule : op_classify
`default_nettype wire

// File: src/ea_adder.sv
`timescale 1ns/1ps
`default_nettype none

module ea_adder (
  // Operands
  input wire logic [15:0] base,
  input wire logic [7:0] offset,
  input wire logic signed_off,
  // Sum
  output logic [15:0] sum
);

  logic [15:0] ext;

  // Index offsets are zero-extended, branch offsets sign-extended
  assign ext = signed_off ? {{8{offset[7]}}, offset} : {8'h00, offset};
  // Sum wraps modulo 64 Kbyte
  assign sum = base + ext;

endmodule : ea_adder
`default_nettype wire

// File: src/operand_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_addr_regs.svh"

// Functional notes
// - Seventeen addressing modes in ten families
// - Inherent: opcode byte only
// - Immediate: opcode plus operand byte
// - Short direct: one address byte, page zero
// - Long direct: two-byte address word
// - Read-modify-write opcodes use short modes only
// - Long modes reach full space, more bytes
// - Indexed: unsigned index plus offset sum
// - No-offset indexed: index alone, page zero
// - Short indexed: byte offset, up to 1FE
// - Long indexed: word offset plus index
// - Indirect: page-zero pointer read from memory
// - Short indirect: byte pointer, page zero
// - Indirect indexed: pointer plus index register
// - Mask instruction sets level three
// - Unmask instruction clears level zero
// - Sleep instruction waits for interrupt
// - Halt instruction stops main oscillator
// - Relative: PC plus signed 8-bit offset
// - Prebytes select Y and indirect forms
module operand_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction byte stream
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  input wire logic [15:0] fetch_pc,
  output logic fetch_ready,
  // Data memory pointer reads
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  // Index registers
  input wire logic [7:0] x_val,
  input wire logic [7:0] y_val,
  // Decoded result
  output logic ea_valid,
  output cpu_addr_pkg::result_t result,
  // Interrupt and power
  input wire logic irq_req,
  output logic [1:0] irq_mask,
  output logic sleep_active,
  output logic osc_stop
);

  cpu_addr_pkg::state_t state_reg;
  cpu_addr_pkg::mode_t mode_reg;
  cpu_addr_pkg::mode_t mode_next;
  cpu_addr_pkg::opclass_t cls;
  cpu_addr_pkg::result_t result_reg;
  logic use_y_reg;
  logic ind_reg;
  logic pre_reg;
  logic rmw_reg;
  logic mask_set_reg;
  logic mask_clr_reg;
  logic wfi_reg;
  logic halt_reg;
  logic [2:0] len_reg;
  logic [15:0] pc_reg;
  logic [7:0] a1_reg;
  logic [7:0] a2_reg;
  logic [7:0] rel_reg;
  logic [15:0] ptr_reg;
  logic [15:0] ptr_addr_reg;
  logic [1:0] irq_mask_reg;
  logic ea_valid_reg;
  logic take;
  logic is_pre;
  logic word_ptr;
  logic [7:0] idx;
  logic [15:0] idx_base;
  logic [15:0] idx_sum;
  logic [7:0] rel_off;
  logic [15:0] pc_after;
  logic [15:0] rel_sum;

  op_classify u_classify (
    .opcode(fetch_byte),
    .cls(cls)
  );

  assign fetch_ready = (state_reg == cpu_addr_pkg::ST_OPC) || (state_reg == cpu_addr_pkg::ST_A1)
    || (state_reg == cpu_addr_pkg::ST_A2) || (state_reg == cpu_addr_pkg::ST_REL);
  assign take = fetch_valid && fetch_ready;
  assign is_pre = (fetch_byte == `PRE_SWAP_Y) || (fetch_byte == `PRE_IND_Y)
    || (fetch_byte == `PRE_IND);
  assign word_ptr = (mode_reg == cpu_addr_pkg::M_LIND) || (mode_reg == cpu_addr_pkg::M_LIIDX);
  assign mem_req = (state_reg == cpu_addr_pkg::ST_P1) || (state_reg == cpu_addr_pkg::ST_P2);
  assign mem_addr = ptr_addr_reg;
  assign sleep_active = (state_reg == cpu_addr_pkg::ST_SLEEP);
  assign osc_stop = (state_reg == cpu_addr_pkg::ST_HALT);
  assign ea_valid = ea_valid_reg;
  assign result = result_reg;
  assign irq_mask = irq_mask_reg;

  // Family plus prebyte gives the mode
  always_comb begin
    case (cls.family)
      cpu_addr_pkg::F_IMM: mode_next = cpu_addr_pkg::M_IMM;
      cpu_addr_pkg::F_SDIR: mode_next = ind_reg ? cpu_addr_pkg::M_SIND : cpu_addr_pkg::M_SDIR;
      cpu_addr_pkg::F_LDIR: mode_next = ind_reg ? cpu_addr_pkg::M_LIND : cpu_addr_pkg::M_LDIR;
      cpu_addr_pkg::F_IDX0: mode_next = cpu_addr_pkg::M_IDX0;
      cpu_addr_pkg::F_SIDX: mode_next = ind_reg ? cpu_addr_pkg::M_SIIDX : cpu_addr_pkg::M_SIDX;
      cpu_addr_pkg::F_LIDX: mode_next = ind_reg ? cpu_addr_pkg::M_LIIDX : cpu_addr_pkg::M_LIDX;
      cpu_addr_pkg::F_REL: mode_next = ind_reg ? cpu_addr_pkg::M_RELI : cpu_addr_pkg::M_RELD;
      cpu_addr_pkg::F_BIT: mode_next = ind_reg ? cpu_addr_pkg::M_BITI : cpu_addr_pkg::M_BITD;
      cpu_addr_pkg::F_BITREL: mode_next = ind_reg ? cpu_addr_pkg::M_BITRI : cpu_addr_pkg::M_BITRD;
      default: mode_next = cpu_addr_pkg::M_INH;
    endcase
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= cpu_addr_pkg::ST_OPC;
    end else begin
      case (state_reg)
        cpu_addr_pkg::ST_OPC: begin
          if (take && !is_pre) begin
            if (mode_next == cpu_addr_pkg::M_INH || mode_next == cpu_addr_pkg::M_IDX0) begin
              state_reg <= cpu_addr_pkg::ST_OUT;
            end else begin
              state_reg <= cpu_addr_pkg::ST_A1;
            end
          end
        end
        cpu_addr_pkg::ST_A1: begin
          if (take) begin
            case (mode_reg)
              cpu_addr_pkg::M_LDIR, cpu_addr_pkg::M_LIDX: state_reg <= cpu_addr_pkg::ST_A2;
              cpu_addr_pkg::M_BITRD, cpu_addr_pkg::M_BITRI: state_reg <= cpu_addr_pkg::ST_REL;
              cpu_addr_pkg::M_SIND, cpu_addr_pkg::M_LIND, cpu_addr_pkg::M_SIIDX,
              cpu_addr_pkg::M_LIIDX, cpu_addr_pkg::M_RELI, cpu_addr_pkg::M_BITI:
                state_reg <= cpu_addr_pkg::ST_P1;
              default: state_reg <= cpu_addr_pkg::ST_OUT;
            endcase
          end
        end
        cpu_addr_pkg::ST_A2: begin
          if (take) begin
            state_reg <= cpu_addr_pkg::ST_OUT;
          end
        end
        cpu_addr_pkg::ST_REL: begin
          if (take) begin
            state_reg <= (mode_reg == cpu_addr_pkg::M_BITRI) ? cpu_addr_pkg::ST_P1
              : cpu_addr_pkg::ST_OUT;
          end
        end
        cpu_addr_pkg::ST_P1: begin
          if (mem_rvalid) begin
            state_reg <= word_ptr ? cpu_addr_pkg::ST_P2 : cpu_addr_pkg::ST_OUT;
          end
        end
        cpu_addr_pkg::ST_P2: begin
          if (mem_rvalid) begin
            state_reg <= cpu_addr_pkg::ST_OUT;
          end
        end
        cpu_addr_pkg::ST_OUT: begin
          if (wfi_reg) begin
            state_reg <= cpu_addr_pkg::ST_SLEEP;
          end else if (halt_reg) begin
            state_reg <= cpu_addr_pkg::ST_HALT;
          end else begin
            state_reg <= cpu_addr_pkg::ST_OPC;
          end
        end
        cpu_addr_pkg::ST_SLEEP, cpu_addr_pkg::ST_HALT: begin
          if (irq_req) begin
            state_reg <= cpu_addr_pkg::ST_OPC;
          end
        end
        default: state_reg <= cpu_addr_pkg::ST_OPC;
      endcase
    end
  end

  // Prebyte, opcode and argument capture
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= cpu_addr_pkg::M_INH;
      {use_y_reg, ind_reg, pre_reg, rmw_reg} <= 4'h0;
      {mask_set_reg, mask_clr_reg, wfi_reg, halt_reg} <= 4'h0;
      len_reg <= `LEN_RST;
      pc_reg <= `ADDR_RST;
      a1_reg <= `BYTE_RST;
      a2_reg <= `BYTE_RST;
      rel_reg <= `BYTE_RST;
    end else if (take) begin
      len_reg <= len_reg + 3'h1;
      if (state_reg == cpu_addr_pkg::ST_OPC) begin
        if (len_reg == `LEN_RST) begin
          pc_reg <= fetch_pc;
        end
        if (is_pre) begin
          pre_reg <= 1'b1;
          use_y_reg <= (fetch_byte != `PRE_IND);
          ind_reg <= (fetch_byte != `PRE_SWAP_Y);
        end else begin
          mode_reg <= mode_next;
          rmw_reg <= cls.rmw;
          mask_set_reg <= cls.mask_set;
          mask_clr_reg <= cls.mask_clr;
          wfi_reg <= cls.sleep_until_irq_instr;
          halt_reg <= cls.halt;
        end
      end else if (state_reg == cpu_addr_pkg::ST_A1) begin
        a1_reg <= fetch_byte;
      end else if (state_reg == cpu_addr_pkg::ST_A2) begin
        a2_reg <= fetch_byte;
      end else begin
        rel_reg <= fetch_byte;
      end
    end else if (state_reg == cpu_addr_pkg::ST_OUT) begin
      len_reg <= `LEN_RST;
      {use_y_reg, ind_reg, pre_reg} <= 3'h0;
    end
  end

  // Pointer read from page zero, high byte first
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_reg <= `ADDR_RST;
      ptr_addr_reg <= `ADDR_RST;
    end else if (take && state_reg == cpu_addr_pkg::ST_A1) begin
      ptr_addr_reg <= {`PAGE_ZERO, fetch_byte};
    end else if (mem_rvalid && state_reg == cpu_addr_pkg::ST_P1) begin
      ptr_addr_reg <= ptr_addr_reg + 16'h0001;
      ptr_reg <= word_ptr ? {mem_rdata, `BYTE_RST} : {`PAGE_ZERO, mem_rdata};
    end else if (mem_rvalid && state_reg == cpu_addr_pkg::ST_P2) begin
      ptr_reg <= {ptr_reg[15:8], mem_rdata};
    end
  end

  // Address arithmetic
  assign idx = use_y_reg ? y_val : x_val;
  always_comb begin
    case (mode_reg)
      cpu_addr_pkg::M_LIDX: idx_base = {a1_reg, a2_reg};
      cpu_addr_pkg::M_SIIDX, cpu_addr_pkg::M_LIIDX: idx_base = ptr_reg;
      cpu_addr_pkg::M_IDX0: idx_base = `ADDR_RST;
      default: idx_base = {`PAGE_ZERO, a1_reg};
    endcase
  end
  assign rel_off = (mode_reg == cpu_addr_pkg::M_RELI) ? ptr_reg[7:0]
    : (mode_reg == cpu_addr_pkg::M_RELD) ? a1_reg : rel_reg;
  assign pc_after = pc_reg + {13'h0000, len_reg};

  ea_adder u_index_add (
    .base(idx_base),
    .offset(idx),
    .signed_off(1'b0),
    .sum(idx_sum)
  );

  ea_adder u_branch_add (
    .base(pc_after),
    .offset(rel_off),
    .signed_off(1'b1),
    .sum(rel_sum)
  );

  // Result register
  always_ff @(posedge clk) begin
    if (srst) begin
      result_reg <= '0;
      ea_valid_reg <= 1'b0;
    end else begin
      ea_valid_reg <= (state_reg == cpu_addr_pkg::ST_OUT);
      if (state_reg == cpu_addr_pkg::ST_OUT) begin
        result_reg.mode <= mode_reg;
        result_reg.length <= len_reg;
        result_reg.prebyte <= pre_reg;
        result_reg.use_y <= use_y_reg;
        result_reg.rmw <= rmw_reg;
        result_reg.operand <= a1_reg;
        result_reg.target <= rel_sum;
        case (mode_reg)
          cpu_addr_pkg::M_LDIR: result_reg.addr <= {a1_reg, a2_reg};
          cpu_addr_pkg::M_IDX0, cpu_addr_pkg::M_SIDX, cpu_addr_pkg::M_LIDX,
          cpu_addr_pkg::M_SIIDX, cpu_addr_pkg::M_LIIDX: result_reg.addr <= idx_sum;
          cpu_addr_pkg::M_SIND, cpu_addr_pkg::M_LIND, cpu_addr_pkg::M_BITI,
          cpu_addr_pkg::M_BITRI: result_reg.addr <= ptr_reg;
          cpu_addr_pkg::M_INH, cpu_addr_pkg::M_IMM, cpu_addr_pkg::M_RELD,
          cpu_addr_pkg::M_RELI: result_reg.addr <= `ADDR_RST;
          default: result_reg.addr <= {`PAGE_ZERO, a1_reg};
        endcase
      end
    end
  end

  // Interrupt mask level
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_mask_reg <= `IRQ_MASK_RST;
    end else if (state_reg == cpu_addr_pkg::ST_OUT && mask_set_reg) begin
      irq_mask_reg <= `IRQ_LEVEL_MAX;
    end else if (state_reg == cpu_addr_pkg::ST_OUT && mask_clr_reg) begin
      irq_mask_reg <= `IRQ_LEVEL_MIN;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_out_valid;
    (state_reg == cpu_addr_pkg::ST_OUT) ##1 ea_valid;
  endsequence

  property p_inh_len;
    ea_valid && result.mode == cpu_addr_pkg::M_INH |-> result.length == 3'd1 + 3'(result.prebyte);
  endproperty
  a_inh_len: assert property (p_inh_len) else $error("inherent length wrong");

  property p_imm_len;
    ea_valid && result.mode == cpu_addr_pkg::M_IMM |-> result.length == 3'd2 + 3'(result.prebyte);
  endproperty
  a_imm_len: assert property (p_imm_len) else $error("immediate length wrong");

  property p_sdir_page;
    ea_valid && result.mode == cpu_addr_pkg::M_SDIR |-> result.addr[15:8] == 8'h00
      && result.length == 3'd2 + 3'(result.prebyte);
  endproperty
  a_sdir_page: assert property (p_sdir_page) else $error("short direct off page zero");

  property p_ldir_len;
    ea_valid && result.mode == cpu_addr_pkg::M_LDIR |-> result.length == 3'd3 + 3'(result.prebyte);
  endproperty
  a_ldir_len: assert property (p_ldir_len) else $error("long direct length wrong");

  property p_rmw_short;
    ea_valid && result.rmw |-> !(result.mode inside {cpu_addr_pkg::M_LDIR, cpu_addr_pkg::M_LIDX,
      cpu_addr_pkg::M_LIND, cpu_addr_pkg::M_LIIDX});
  endproperty
  a_rmw_short: assert property (p_rmw_short) else $error("long mode on memory operation");

  property p_sidx_limit;
    ea_valid && result.mode inside {cpu_addr_pkg::M_SIDX, cpu_addr_pkg::M_SIIDX}
      |-> result.addr <= `SIDX_LIMIT;
  endproperty
  a_sidx_limit: assert property (p_sidx_limit) else $error("short indexed beyond 1FE");

  property p_ptr_word;
    state_reg == cpu_addr_pkg::ST_P1 && mem_rvalid && word_ptr |=> state_reg == cpu_addr_pkg::ST_P2
      && mem_addr == $past(mem_addr) + 16'h0001;
  endproperty
  a_ptr_word: assert property (p_ptr_word) else $error("word pointer second read missing");

  property p_mask_set;
    mask_set_reg ##0 s_out_valid |-> irq_mask == `IRQ_LEVEL_MAX;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set to top level");

  property p_mask_clr;
    state_reg == cpu_addr_pkg::ST_OUT && mask_clr_reg && !mask_set_reg
      |=> irq_mask == `IRQ_LEVEL_MIN;
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask not cleared");

  property p_sleep_hold;
    sleep_active && !irq_req |=> sleep_active && !fetch_ready;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without interrupt");

  property p_halt_hold;
    osc_stop && !irq_req |=> osc_stop && !ea_valid;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left without interrupt");

endmodule : operand_decoder
`default_nettype wire

// File: sim/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pointer read port
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_rvalid,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [256];
  int wait_cnt;
  // Page-zero pointer reads, answered after 0 to 3 idle cycles
  always @(posedge clk) begin
    if (srst) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= 8'h00;
      wait_cnt <= 0;
    end else if (mem_rvalid) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= $urandom_range(3);
    end else if (mem_req && wait_cnt == 0) begin
      mem_rvalid <= 1'b1;
      mem_rdata <= mem[mem_addr[7:0]];
    end else begin
      // Idle data keeps toggling
      mem_rdata <= ~mem_rdata;
      if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : mem_model
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {cpu_addr_pkg::result_t r; logic chk_op; logic chk_tgt;} note_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic fetch_valid = 1'b0;
  logic irq_req = 1'b0;
  logic [7:0] fetch_byte = 8'h00;
  logic [7:0] x_val = 8'h00;
  logic [7:0] y_val = 8'h00;
  logic [15:0] fetch_pc = 16'h0000;
  logic fetch_ready, mem_req, mem_rvalid, ea_valid, sleep_active, osc_stop;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  logic [1:0] irq_mask;
  cpu_addr_pkg::result_t result;
  int err_count = 0;
  int cmp_count = 0;
  note_t q[$];
  note_t nt;
  logic [7:0] pre_tab [27] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h90, 8'h90, 8'h92, 8'h92, 8'h92, 8'h92,
    8'h92, 8'h92, 8'h92, 8'h92, 8'h91, 8'h91};
  logic [3:0] nib_tab [27] = '{4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h2, 4'h1, 4'h0, 4'h3,
    4'h6, 4'h7, 4'h4, 4'h5, 4'hD, 4'hE, 4'hF, 4'hB, 4'hC, 4'hD, 4'hE, 4'h2, 4'h1, 4'h0,
    4'h3, 4'hD, 4'hE};

  always #10 clk = ~clk;

  operand_decoder u_operand_decoder (.clk(clk), .srst(srst), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte), .fetch_pc(fetch_pc), .fetch_ready(fetch_ready),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .x_val(x_val), .y_val(y_val), .ea_valid(ea_valid), .result(result), .irq_req(irq_req),
    .irq_mask(irq_mask), .sleep_active(sleep_active), .osc_stop(osc_stop));

  mem_model u_mem_model (.clk(clk), .srst(srst), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  function automatic logic [7:0] pat(input logic [7:0] a);
    return (a * 8'h3B) + 8'h17;
  endfunction : pat

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic send(input logic [7:0] b, input logic first, input logic [15:0] pc,
                      input logic [7:0] xv, input logic [7:0] yv);
    int n;
    n = 0;
    @(negedge clk);
    while (fetch_ready !== 1'b1 && n < 200) begin
      fetch_valid = 1'b0;
      fetch_byte = ~b;
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      end_of_test();
    end
    fetch_valid = 1'b1;
    fetch_byte = b;
    if (first) begin
      fetch_pc = pc;
      x_val = xv;
      y_val = yv;
    end
  endtask : send

  task automatic do_instr(input logic [7:0] pre, input logic [7:0] op, input logic [7:0] a1,
                          input logic [7:0] a2, input logic [15:0] pc, input logic [7:0] xv,
                          input logic [7:0] yv);
    note_t e;
    logic [7:0] by[$];
    logic [7:0] idx, off, b;
    logic ind, y;
    logic [15:0] w;
    ind = (pre == 8'h92) || (pre == 8'h91);
    y = (pre == 8'h90) || (pre == 8'h91);
    idx = y ? yv : xv;
    if (ind && (op[7:4] == 4'hC || op[7:4] == 4'hD)) a1[0] = 1'b0;
    w = {pat(a1), pat(a1 + 8'h01)};
    b = ind ? pat(a1) : a1;
    off = 8'h00;
    e.r = '0;
    e.chk_op = 1'b0;
    e.chk_tgt = 1'b0;
    e.r.prebyte = (pre != 8'h00);
    e.r.use_y = y;
    e.r.rmw = op[7:4] inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h7};
    if (pre != 8'h00) by.push_back(pre);
    by.push_back(op);
    case (op[7:4])
      4'hA: begin
        e.r.mode = cpu_addr_pkg::M_IMM;
        e.r.operand = a1;
        e.chk_op = 1'b1;
        by.push_back(a1);
      end
      4'hB, 4'h3: begin
        e.r.mode = ind ? cpu_addr_pkg::M_SIND : cpu_addr_pkg::M_SDIR;
        e.r.addr = {8'h00, b};
        by.push_back(a1);
      end
      4'hC: begin
        e.r.mode = ind ? cpu_addr_pkg::M_LIND : cpu_addr_pkg::M_LDIR;
        e.r.addr = ind ? w : {a1, a2};
        by.push_back(a1);
        if (!ind) by.push_back(a2);
      end
      4'hD: begin
        e.r.mode = ind ? cpu_addr_pkg::M_LIIDX : cpu_addr_pkg::M_LIDX;
        e.r.addr = (ind ? w : {a1, a2}) + {8'h00, idx};
        by.push_back(a1);
        if (!ind) by.push_back(a2);
      end
      4'hE, 4'h6: begin
        e.r.mode = ind ? cpu_addr_pkg::M_SIIDX : cpu_addr_pkg::M_SIDX;
        e.r.addr = {8'h00, b} + {8'h00, idx};
        by.push_back(a1);
      end
      4'hF, 4'h7: begin
        e.r.mode = cpu_addr_pkg::M_IDX0;
        e.r.addr = {8'h00, idx};
      end
      4'h2: begin
        e.r.mode = ind ? cpu_addr_pkg::M_RELI : cpu_addr_pkg::M_RELD;
        off = b;
        by.push_back(a1);
      end
      4'h1: begin
        e.r.mode = ind ? cpu_addr_pkg::M_BITI : cpu_addr_pkg::M_BITD;
        e.r.addr = {8'h00, b};
        by.push_back(a1);
      end
      4'h0: begin
        e.r.mode = ind ? cpu_addr_pkg::M_BITRI : cpu_addr_pkg::M_BITRD;
        e.r.addr = {8'h00, b};
        off = a2;
        by.push_back(a1);
        by.push_back(a2);
      end
      default: e.r.mode = cpu_addr_pkg::M_INH;
    endcase
    e.r.length = 3'(by.size());
    if (op[7:4] == 4'h2 || op[7:4] == 4'h0) begin
      e.chk_tgt = 1'b1;
      e.r.target = pc + 16'(by.size()) + {{8{off[7]}}, off};
    end
    q.push_back(e);
    foreach (by[i]) send(by[i], i == 0, pc, xv, yv);
  endtask : do_instr

  task automatic drain();
    int n;
    n = 0;
    @(negedge clk);
    fetch_valid = 1'b0;
    while (q.size() > 0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      end_of_test();
    end
    repeat (3) @(negedge clk);
  endtask : drain

  task automatic low_power(input logic [7:0] op, input logic halt);
    int n;
    n = 0;
    do_instr(8'h00, op, 8'h00, 8'h00, 16'h2000, 8'h00, 8'h00);
    @(negedge clk);
    fetch_valid = 1'b0;
    while ((halt ? osc_stop : sleep_active) !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end
    repeat (4) @(negedge clk);
    chk("low_power", {31'h0, halt ? osc_stop : sleep_active}, 32'h1);
    chk("ready_in_low_power", {31'h0, fetch_ready}, 32'h0);
    irq_req = 1'b1;
    n = 0;
    while ((halt ? osc_stop : sleep_active) !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end
    chk("woken", {31'h0, halt ? osc_stop : sleep_active}, 32'h0);
    irq_req = 1'b0;
    repeat (5) @(negedge clk);
  endtask : low_power

  // Result watcher
  always @(negedge clk) begin
    if (srst === 1'b0 && ea_valid === 1'b1) begin
      if (q.size() == 0) begin
        chk("unexpected_ea_valid", 32'h1, 32'h0);
      end else begin
        nt = q.pop_front();
        chk("mode", 32'(result.mode), 32'(nt.r.mode));
        chk("addr", 32'(result.addr), 32'(nt.r.addr));
        chk("length", 32'(result.length), 32'(nt.r.length));
        chk("flags", {29'h0, result.prebyte, result.use_y, result.rmw},
            {29'h0, nt.r.prebyte, nt.r.use_y, nt.r.rmw});
        if (nt.chk_op) chk("operand", 32'(result.operand), 32'(nt.r.operand));
        if (nt.chk_tgt) chk("target", 32'(result.target), 32'(nt.r.target));
      end
    end
  end

  initial begin
    void'($urandom(32'hBC57CB87));
    for (int i = 0; i < 256; i++) u_mem_model.mem[i] = pat(8'(i));
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    chk("reset_outs", {27'h0, fetch_ready, mem_req, ea_valid, sleep_active, osc_stop},
        32'h10);
    chk("reset_mask", 32'(irq_mask), 32'h3);
    for (int k = 0; k < 27; k++) begin
      repeat (2) do_instr(pre_tab[k], {nib_tab[k], 4'($urandom)}, 8'($urandom), 8'($urandom),
                          16'($urandom), 8'($urandom), 8'($urandom));
    end
    do_instr(8'h00, 8'hE3, 8'hFF, 8'h00, 16'h0100, 8'hFF, 8'h00);
    do_instr(8'h00, 8'hD3, 8'hFF, 8'hFF, 16'hFFFE, 8'hFF, 8'h00);
    do_instr(8'h00, 8'h2C, 8'h80, 8'h00, 16'h0001, 8'h00, 8'h00);
    drain();
    do_instr(8'h00, 8'h9A, 8'h00, 8'h00, 16'h1000, 8'h00, 8'h00);
    drain();
    chk("unmask_level", 32'(irq_mask), 32'h0);
    do_instr(8'h00, 8'h9B, 8'h00, 8'h00, 16'h1001, 8'h00, 8'h00);
    drain();
    chk("mask_level", 32'(irq_mask), 32'h3);
    low_power(8'h8F, 1'b0);
    low_power(8'h8E, 1'b1);
    do_instr(8'h92, 8'hC4, 8'h20, 8'h00, 16'h3000, 8'h00, 8'h00);
    drain();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
